// ==== shared/dctr_pkg.sv ====
// Purpose: shared constants and types of the dual channel temperature readout
// Assumes: mclk at 200 MHz
// Notes: register pointer values are the command byte values on the bus
package dctr_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int SPIKE_NS = 50;
   localparam int FILT_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam logic [3:0] FILT_LAST = 4'(FILT_CYCLES - 1);
   localparam int BUS_STUCK_TIMEOUT_MS = 30;
   localparam int BUS_STUCK_TIMEOUT_CYCLES = BUS_STUCK_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CONV_TIME_MS = 125;
   localparam int CONV_TIME_CYCLES = CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SCL_MAX_KHZ = 100;
   // ****************************************
   // register pointers
   // ****************************************
   localparam logic [7:0] REG_LOCAL_INT = 8'h00;
   localparam logic [7:0] REG_REMOTE_INT = 8'h01;
   localparam logic [7:0] REG_STATUS = 8'h02;
   localparam logic [7:0] REG_CONFIG = 8'h03;
   localparam logic [7:0] REG_LOCAL_LIMIT = 8'h05;
   localparam logic [7:0] REG_REMOTE_LIMIT = 8'h07;
   localparam logic [7:0] REG_ONE_SHOT = 8'h0f;
   localparam logic [7:0] REG_LOCAL_EXT = 8'h10;
   localparam logic [7:0] REG_REMOTE_EXT = 8'h11;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int CFG_STANDBY_BIT = 6;
   localparam int CFG_REMOTE_ONLY_BIT = 4;
   localparam int STAT_FAULT_BIT = 2;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] LOCAL_LIMIT_RST = 8'h46;
   localparam logic [7:0] REMOTE_LIMIT_RST = 8'h78;
   localparam logic [7:0] FAULT_TEMP = 8'hff;
   // arbitrary target address
   localparam logic [6:0] TARGET_ADDR_DFLT = 7'h2a;
   // ****************************************
   // states
   // ****************************************
   typedef enum logic [3:0] {
      BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_CMD, BUS_CMD_ACK,
      BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RACK
   } dctr_bus_state_type;
   typedef enum logic [1:0] {CONV_IDLE, CONV_REMOTE, CONV_LOCAL} dctr_conv_state_type;
endpackage

// ==== src/dctr_pin_filter.sv ====
// Purpose: two flop synchroniser and spike filter for one bus pin
// Assumes: idle level of the pin is high
// Notes: output follows only after FILT_CYCLES equal samples
`timescale 1ns/1ps
module dctr_pin_filter
   import dctr_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // pin
   input wire logic pin_raw,
   output logic pin_clean
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [3:0] cnt;
      logic clean;
   } dctr_filt_type;

   dctr_filt_type s;
   dctr_filt_type next_s;

   always_comb begin
      next_s = s;
      next_s.sync1 = pin_raw;
      next_s.sync2 = s.sync1;
      if (s.sync2 != s.clean) begin
         if (s.cnt == FILT_LAST) begin
            next_s.clean = s.sync2;
            next_s.cnt = 4'h0;
         end else begin
            next_s.cnt = s.cnt + 4'h1;
         end
      end else begin
         next_s.cnt = 4'h0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s <= '{sync1: 1'b1, sync2: 1'b1, cnt: 4'h0, clean: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign pin_clean = s.clean;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   spike_reject_a: assert property ($changed(s.clean) |-> $past(s.cnt) == FILT_LAST)
      else $error("filtered pin changed before the spike window");
endmodule

// ==== src/dctr_readout.sv ====
// Purpose: two channel temperature readout with smbus target and over-limit output
// Assumes: adc samples and fault flag come from logic on mclk
// Notes: sda and alert are open drain; oe_n low pulls the wire low
`timescale 1ns/1ps
module dctr_readout
   import dctr_pkg::*;
#(
   parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DFLT,
   parameter int unsigned CONV_CYCLES = CONV_TIME_CYCLES,
   parameter int unsigned TIMEOUT_CYCLES = BUS_STUCK_TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // smbus pins
   input wire logic smb_clk,
   input wire logic smb_data_in,
   output logic smb_data_out,
   output logic smb_data_oe_n,
   // over-limit pin
   output logic alert_out,
   output logic alert_oe_n,
   // converter samples
   input wire logic [9:0] local_sample,
   input wire logic [9:0] remote_sample,
   input wire logic remote_junction_fault
);
   localparam logic [24:0] CONV_LAST = 25'(CONV_CYCLES - 1);
   localparam logic [24:0] TMO_LAST = 25'(TIMEOUT_CYCLES - 1);

   typedef struct packed {
      dctr_bus_state_type bus;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic acked;
      logic [7:0] pointer;
      logic scl_q;
      logic sda_q;
      logic sda_oe_n;
      logic [24:0] tmo_cnt;
      dctr_conv_state_type conv;
      logic [24:0] conv_cnt;
      logic oneshot_pend;
      logic single;
      logic standby_q;
      logic [7:0] local_int;
      logic [7:0] remote_int;
      logic [7:0] local_ext;
      logic [7:0] remote_ext;
      logic [7:0] status;
      logic [7:0] config_reg;
      logic [7:0] local_limit;
      logic [7:0] remote_limit;
      logic alert_oe_n;
      logic pin_low;
   } dctr_state_type;

   dctr_state_type s;
   dctr_state_type next_s;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic tmo_hit;
   logic standby;
   logic abort_now;
   logic slot_end;
   logic latch_remote;
   logic latch_local;
   logic alarm_now;
   logic [7:0] rdata;

   // ****************************************
   // pin conditioning
   // ****************************************
   dctr_pin_filter u_clk_filter (
      .mclk(mclk),
      .reset(reset),
      .pin_raw(smb_clk),
      .pin_clean(scl)
   );
   dctr_pin_filter u_data_filter (
      .mclk(mclk),
      .reset(reset),
      .pin_raw(smb_data_in),
      .pin_clean(sda)
   );

   // ****************************************
   // decode and read mux
   // ****************************************
   assign scl_rise = scl && !s.scl_q;
   assign scl_fall = !scl && s.scl_q;
   assign start_seen = scl && s.scl_q && s.sda_q && !sda;
   assign stop_seen = scl && s.scl_q && !s.sda_q && sda;
   assign tmo_hit = (!scl || !sda) && s.tmo_cnt == TMO_LAST;
   assign standby = s.config_reg[CFG_STANDBY_BIT];
   assign abort_now = s.conv != CONV_IDLE && !s.single && standby && !s.standby_q;
   assign slot_end = s.conv != CONV_IDLE && s.conv_cnt == CONV_LAST;
   assign latch_remote = slot_end && s.conv == CONV_REMOTE && !abort_now;
   assign latch_local = slot_end && s.conv == CONV_LOCAL && !abort_now;
   assign alarm_now = s.local_int >= s.local_limit
      || (!s.status[STAT_FAULT_BIT] && s.remote_int >= s.remote_limit);

   always_comb begin
      case (s.pointer)
         REG_LOCAL_INT: rdata = s.local_int;
         REG_REMOTE_INT: rdata = s.remote_int;
         REG_STATUS: rdata = s.status;
         REG_CONFIG: rdata = s.config_reg;
         REG_LOCAL_LIMIT: rdata = s.local_limit;
         REG_REMOTE_LIMIT: rdata = s.remote_limit;
         REG_LOCAL_EXT: rdata = s.local_ext;
         REG_REMOTE_EXT: rdata = s.remote_ext;
         default: rdata = 8'h00;
      endcase
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_s = s;
      next_s.scl_q = scl;
      next_s.sda_q = sda;
      next_s.standby_q = standby;
      next_s.alert_oe_n = !alarm_now;
      // bus stuck timer
      if (!scl || !sda) begin
         if (s.tmo_cnt != TMO_LAST) begin
            next_s.tmo_cnt = s.tmo_cnt + 25'h000_0001;
         end
      end else begin
         next_s.tmo_cnt = 25'h000_0000;
      end
      // converter sequencing; runs even while the bus is busy
      if (s.conv != CONV_IDLE) begin
         next_s.oneshot_pend = 1'b0;
      end
      if (abort_now) begin
         next_s.conv = CONV_IDLE;
         next_s.conv_cnt = 25'h000_0000;
      end else begin
         case (s.conv)
            CONV_IDLE: begin
               next_s.conv_cnt = 25'h000_0000;
               if (s.oneshot_pend) begin
                  next_s.oneshot_pend = 1'b0;
                  next_s.single = standby;
                  next_s.conv = CONV_REMOTE;
               end else if (!standby) begin
                  next_s.single = 1'b0;
                  next_s.conv = CONV_REMOTE;
               end
            end
            CONV_REMOTE: begin
               if (slot_end) begin
                  next_s.conv_cnt = 25'h000_0000;
                  if (!s.config_reg[CFG_REMOTE_ONLY_BIT]) begin
                     next_s.conv = CONV_LOCAL;
                  end else if (s.single || standby) begin
                     next_s.conv = CONV_IDLE;
                  end else begin
                     next_s.conv = CONV_REMOTE;
                  end
               end else begin
                  next_s.conv_cnt = s.conv_cnt + 25'h000_0001;
               end
            end
            CONV_LOCAL: begin
               if (slot_end) begin
                  next_s.conv_cnt = 25'h000_0000;
                  if (s.single || standby) begin
                     next_s.conv = CONV_IDLE;
                  end else begin
                     next_s.conv = CONV_REMOTE;
                  end
               end else begin
                  next_s.conv_cnt = s.conv_cnt + 25'h000_0001;
               end
            end
            default: next_s.conv = CONV_IDLE;
         endcase
      end
      // results; old values stay until the slot ends
      if (latch_remote) begin
         if (remote_junction_fault) begin
            next_s.remote_int = FAULT_TEMP;
            next_s.remote_ext = 8'h00;
            next_s.status[STAT_FAULT_BIT] = 1'b1;
         end else begin
            next_s.remote_int = remote_sample[9:2];
            next_s.remote_ext = {remote_sample[1:0], 6'b00_0000};
            next_s.status[STAT_FAULT_BIT] = 1'b0;
         end
      end
      if (latch_local) begin
         next_s.local_int = local_sample[9:2];
         next_s.local_ext = {local_sample[1:0], 6'b00_0000};
      end
      // smbus target; stays active in standby
      if (tmo_hit) begin
         next_s.bus = BUS_IDLE;
         next_s.sda_oe_n = 1'b1;
      end else if (start_seen) begin
         next_s.bus = BUS_ADDR;
         next_s.bitcnt = 4'h0;
         next_s.sda_oe_n = 1'b1;
      end else if (stop_seen) begin
         next_s.bus = BUS_IDLE;
         next_s.sda_oe_n = 1'b1;
      end else begin
         case (s.bus)
            BUS_ADDR, BUS_CMD, BUS_WDATA: begin
               if (scl_rise) begin
                  next_s.shreg = {s.shreg[6:0], sda};
                  next_s.bitcnt = s.bitcnt + 4'h1;
               end else if (scl_fall && s.bitcnt == 4'h8) begin
                  next_s.bitcnt = 4'h0;
                  next_s.sda_oe_n = 1'b0;
                  if (s.bus == BUS_ADDR) begin
                     if (s.shreg[7:1] == TARGET_ADDR) begin
                        next_s.rw = s.shreg[0];
                        next_s.bus = BUS_ADDR_ACK;
                     end else begin
                        next_s.sda_oe_n = 1'b1;
                        next_s.bus = BUS_IDLE;
                     end
                  end else if (s.bus == BUS_CMD) begin
                     next_s.pointer = s.shreg;
                     next_s.bus = BUS_CMD_ACK;
                     if (s.shreg == REG_ONE_SHOT) begin
                        next_s.oneshot_pend = 1'b1;
                     end
                  end else begin
                     next_s.bus = BUS_WDATA_ACK;
                     case (s.pointer)
                        REG_CONFIG: next_s.config_reg = s.shreg;
                        REG_LOCAL_LIMIT: next_s.local_limit = s.shreg;
                        REG_REMOTE_LIMIT: next_s.remote_limit = s.shreg;
                        default: next_s.pointer = s.pointer;
                     endcase
                  end
               end
            end
            BUS_ADDR_ACK: begin
               if (scl_fall) begin
                  if (s.rw) begin
                     next_s.shreg = rdata;
                     next_s.sda_oe_n = rdata[7];
                     next_s.bus = BUS_RDATA;
                  end else begin
                     next_s.sda_oe_n = 1'b1;
                     next_s.bus = BUS_CMD;
                  end
               end
            end
            BUS_CMD_ACK: begin
               if (scl_fall) begin
                  next_s.sda_oe_n = 1'b1;
                  next_s.bus = BUS_WDATA;
               end
            end
            BUS_WDATA_ACK: begin
               if (scl_fall) begin
                  next_s.sda_oe_n = 1'b1;
                  next_s.bus = BUS_IDLE;
               end
            end
            BUS_RDATA: begin
               if (scl_rise) begin
                  next_s.bitcnt = s.bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (s.bitcnt == 4'h8) begin
                     next_s.bitcnt = 4'h0;
                     next_s.sda_oe_n = 1'b1;
                     next_s.bus = BUS_RACK;
                  end else begin
                     next_s.shreg = {s.shreg[6:0], 1'b0};
                     next_s.sda_oe_n = s.shreg[6];
                  end
               end
            end
            BUS_RACK: begin
               if (scl_rise) begin
                  next_s.acked = !sda;
               end else if (scl_fall) begin
                  if (s.acked) begin
                     next_s.shreg = rdata;
                     next_s.sda_oe_n = rdata[7];
                     next_s.bus = BUS_RDATA;
                  end else begin
                     next_s.bus = BUS_IDLE;
                  end
               end
            end
            default: next_s.bus = BUS_IDLE;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s <= '0;
         s.bus <= BUS_IDLE;
         s.conv <= CONV_IDLE;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
         s.sda_oe_n <= 1'b1;
         s.alert_oe_n <= 1'b1;
         s.config_reg <= CONFIG_RST;
         s.local_limit <= LOCAL_LIMIT_RST;
         s.remote_limit <= REMOTE_LIMIT_RST;
      end else begin
         s <= next_s;
      end
   end

   assign smb_data_out = s.pin_low;
   assign smb_data_oe_n = s.sda_oe_n;
   assign alert_out = s.pin_low;
   assign alert_oe_n = s.alert_oe_n;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence remote_end_s;
      s.conv == CONV_REMOTE && s.conv_cnt == CONV_LAST && !abort_now;
   endsequence
   sequence local_end_s;
      s.conv == CONV_LOCAL && s.conv_cnt == CONV_LAST && !abort_now;
   endsequence

   stuck_bus_reset_a: assert property (tmo_hit |=> s.bus == BUS_IDLE && s.sda_oe_n)
      else $error("stuck bus did not reset the target");
   alert_compare_a: assert property (##1 s.alert_oe_n == !$past(alarm_now))
      else $error("over-limit output disagrees with comparison");
   channel_order_a: assert property (remote_end_s and ##0 !s.config_reg[CFG_REMOTE_ONLY_BIT]
      |=> s.conv == CONV_LOCAL && s.conv_cnt == 25'h000_0000)
      else $error("local slot did not follow remote slot");
   latch_together_a: assert property (local_end_s |=> s.local_int == $past(local_sample[9:2])
      && s.local_ext[7:6] == $past(local_sample[1:0]))
      else $error("local result bytes not latched together");
   fault_load_a: assert property (remote_end_s and ##0 remote_junction_fault
      |=> s.remote_int == FAULT_TEMP && s.status[STAT_FAULT_BIT])
      else $error("diode fault not reported");
   abort_keep_a: assert property (abort_now |=> s.conv == CONV_IDLE
      && $stable(s.local_int) && $stable(s.remote_int))
      else $error("aborted conversion changed results");
   standby_idle_a: assert property (s.conv == CONV_IDLE && standby && !s.oneshot_pend
      |=> s.conv == CONV_IDLE)
      else $error("converter ran in standby");
   oneshot_return_a: assert property (local_end_s and ##0 s.single
      |=> s.conv == CONV_IDLE)
      else $error("standby one-shot did not return to idle");
   oneshot_start_a: assert property (s.conv == CONV_IDLE && s.oneshot_pend && !abort_now
      |=> s.conv == CONV_REMOTE)
      else $error("one-shot did not start a conversion");
   read_pointer_a: assert property (s.bus == BUS_ADDR_ACK && scl_fall && s.rw && !start_seen
      && !stop_seen && !tmo_hit |=> s.shreg == $past(rdata) && s.bus == BUS_RDATA)
      else $error("read did not load the selected register");
endmodule

// ==== tb/dctr_host_model.sv ====
// Purpose: smbus host model for the temperature readout bench
// Assumes: open drain data wire resolved by the bench, pull-up high
// Notes: bit time scaled down so the run stays short
`timescale 1ns/1ps
module dctr_host_model
   import dctr_pkg::*;
#(
   parameter int HALF = 32
) (
   // clock
   input wire logic mclk,
   // bus wires
   output logic smb_clk,
   output logic sda_drive,
   input wire logic sda_wire
);
   logic glitch_en = 1'b0;
   initial begin
      smb_clk = 1'b1;
      sda_drive = 1'b1;
   end
   // ****************************************
   // bus primitives
   // ****************************************
   task automatic half_wait();
      repeat (HALF) @(negedge mclk);
   endtask
   // data set in clock low, sampled at end of clock high
   task automatic bit_xfer(input logic b, output logic rx);
      sda_drive = b;
      half_wait();
      smb_clk = 1'b1;
      if (glitch_en) begin
         // 24 ns low spikes, a 48 ns link clock
         repeat (3) begin
            #24 smb_clk = 1'b0;
            #24 smb_clk = 1'b1;
         end
      end
      half_wait();
      rx = sda_wire;
      smb_clk = 1'b0;
   endtask
   task automatic start_cond();
      sda_drive = 1'b1;
      half_wait();
      smb_clk = 1'b1;
      half_wait();
      sda_drive = 1'b0;
      half_wait();
      smb_clk = 1'b0;
   endtask
   task automatic stop_cond();
      sda_drive = 1'b0;
      half_wait();
      smb_clk = 1'b1;
      half_wait();
      sda_drive = 1'b1;
      half_wait();
   endtask
   // ninth bit released: ack seen, or nack given on reads
   task automatic byte_xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(tx[i], b);
         rx[i] = b;
      end
      bit_xfer(1'b1, b);
      ack = ~b;
   endtask
   // ****************************************
   // transactions: 0 write, 1 send, 2 read, 3 receive
   // ****************************************
   task automatic trans(input int kind, input logic [6:0] addr, input logic [7:0] cmd,
      input logic [7:0] wdat, output logic [7:0] rdat, output logic acked);
      logic [7:0] junk;
      logic a;
      acked = 1'b1;
      rdat = 8'h00;
      start_cond();
      if (kind != 3) begin
         byte_xfer({addr, 1'b0}, junk, a);
         acked &= a;
         byte_xfer(cmd, junk, a);
         acked &= a;
         if (kind == 0) begin
            byte_xfer(wdat, junk, a);
            acked &= a;
         end
      end
      if (kind >= 2) begin
         if (kind == 2) begin
            start_cond();
         end
         byte_xfer({addr, 1'b1}, junk, a);
         acked &= a;
         byte_xfer(8'hff, rdat, a);
      end
      stop_cond();
   endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench of the dual channel temperature readout
// Assumes: shortened conversion slot and bus timeout
// Notes: host model drives the bus, bench drives converter samples
`timescale 1ns/1ps
module tb
   import dctr_pkg::*;
;
   localparam int CONV = 1500;
   localparam int TMO = 3000;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic smb_clk, sda_drive, sda_wire, smb_data_out, smb_data_oe_n, alert_out, alert_oe_n;
   logic [9:0] local_sample = {8'h19, 2'b01};
   logic [9:0] remote_sample = {8'h82, 2'b11};
   logic remote_junction_fault = 1'b0;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [7:0] rd;
   logic ok;
   logic junk;
   always #2.5 mclk = ~mclk;
   // open drain data wire with pull-up
   assign sda_wire = sda_drive & (smb_data_oe_n | smb_data_out);
   dctr_readout #(.TARGET_ADDR(TARGET_ADDR_DFLT), .CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO))
      dctr_readout_inst (.mclk(mclk), .reset(reset), .smb_clk(smb_clk),
      .smb_data_in(sda_wire), .smb_data_out(smb_data_out), .smb_data_oe_n(smb_data_oe_n),
      .alert_out(alert_out), .alert_oe_n(alert_oe_n), .local_sample(local_sample),
      .remote_sample(remote_sample), .remote_junction_fault(remote_junction_fault));
   dctr_host_model #(.HALF(32)) host_inst (.mclk(mclk), .smb_clk(smb_clk),
      .sda_drive(sda_drive), .sda_wire(sda_wire));
   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input string what, input logic [7:0] ptr, input logic [7:0] exp);
      host_inst.trans(2, TARGET_ADDR_DFLT, ptr, 8'h00, rd, ok);
      check(what, exp, rd);
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
      host_inst.trans(0, TARGET_ADDR_DFLT, ptr, val, rd, ok);
      check("write ack", 8'h01, {7'h00, ok});
   endtask
   task automatic one_shot();
      host_inst.trans(1, TARGET_ADDR_DFLT, REG_ONE_SHOT, 8'h00, rd, ok);
      repeat (2 * CONV + 200) @(negedge mclk);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic sc_por();
      rd_chk("local limit", REG_LOCAL_LIMIT, 8'h46);
      rd_chk("remote limit", REG_REMOTE_LIMIT, 8'h78);
      rd_chk("local temp", REG_LOCAL_INT, 8'h19);
      rd_chk("remote temp", REG_REMOTE_INT, 8'h82);
      rd_chk("local ext", REG_LOCAL_EXT, 8'h40);
      rd_chk("remote ext", REG_REMOTE_EXT, 8'hc0);
      host_inst.trans(3, TARGET_ADDR_DFLT, 8'h00, 8'h00, rd, ok);
      check("receive byte", 8'hc0, rd);
      check("alert", 8'h00, {7'h00, alert_oe_n | alert_out});
   endtask
   task automatic sc_limit();
      wr(REG_REMOTE_LIMIT, 8'h83);
      check("alert below", 8'h01, {7'h00, alert_oe_n | alert_out});
      wr(REG_REMOTE_LIMIT, 8'h82);
      check("alert equal", 8'h00, {7'h00, alert_oe_n | alert_out});
   endtask
   task automatic sc_standby();
      wr(REG_CONFIG, 8'h40);
      local_sample = {8'h1a, 2'b00};
      remote_sample = {8'h30, 2'b10};
      repeat (2 * CONV) @(negedge mclk);
      rd_chk("standby temp", REG_LOCAL_INT, 8'h19);
      rd_chk("standby config", REG_CONFIG, 8'h40);
   endtask
   task automatic sc_one_shot();
      one_shot();
      rd_chk("shot local", REG_LOCAL_INT, 8'h1a);
      rd_chk("shot remote", REG_REMOTE_INT, 8'h30);
      rd_chk("shot ext", REG_REMOTE_EXT, 8'h80);
      local_sample = {8'h1b, 2'b00};
      repeat (2 * CONV) @(negedge mclk);
      rd_chk("after shot", REG_LOCAL_INT, 8'h1a);
   endtask
   task automatic sc_remote_only();
      wr(REG_CONFIG, 8'h50);
      local_sample = {8'h1c, 2'b00};
      remote_sample = {8'h31, 2'b00};
      one_shot();
      rd_chk("skip local", REG_LOCAL_INT, 8'h1a);
      rd_chk("only remote", REG_REMOTE_INT, 8'h31);
      // free running, remote only, from here on
      wr(REG_CONFIG, 8'h10);
   endtask
   task automatic sc_fault();
      remote_junction_fault = 1'b1;
      one_shot();
      rd_chk("fault temp", REG_REMOTE_INT, 8'hff);
      rd_chk("remote only run", REG_LOCAL_INT, 8'h1a);
      host_inst.trans(2, TARGET_ADDR_DFLT, REG_STATUS, 8'h00, rd, ok);
      check("fault flag", 8'h04, rd & 8'h04);
      check("fault alert", 8'h01, {7'h00, alert_oe_n | alert_out});
      remote_junction_fault = 1'b0;
   endtask
   task automatic sc_refused();
      host_inst.trans(0, TARGET_ADDR_DFLT ^ 7'h01, REG_REMOTE_LIMIT, 8'h10, rd, ok);
      check("foreign ack", 8'h00, {7'h00, ok});
      rd_chk("foreign write", REG_REMOTE_LIMIT, 8'h82);
      rd_chk("unmapped", 8'h20, 8'h00);
   endtask
   task automatic sc_glitch();
      host_inst.glitch_en = 1'b1;
      wr(REG_LOCAL_LIMIT, 8'h50);
      host_inst.glitch_en = 1'b0;
      rd_chk("glitch write", REG_LOCAL_LIMIT, 8'h50);
   endtask
   task automatic sc_timeout();
      host_inst.start_cond();
      // address and write bit, then the clock is held low through the ack
      for (int i = 7; i >= 0; i--) begin
         host_inst.bit_xfer(i > 0 ? TARGET_ADDR_DFLT[i - 1] : 1'b0, junk);
      end
      repeat (200) @(negedge mclk);
      check("ack held", 8'h00, {7'h00, smb_data_oe_n});
      repeat (TMO) @(negedge mclk);
      check("bus reset", 8'h01, {7'h00, smb_data_oe_n});
      host_inst.stop_cond();
      rd_chk("after reset", REG_LOCAL_LIMIT, 8'h50);
   endtask
   // ****************************************
   // run
   // ****************************************
   initial begin
      repeat (99000) @(posedge mclk);
      n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (6) @(negedge mclk);
      reset = 1'b0;
      repeat (20) @(negedge mclk);
      sc_por();
      sc_limit();
      sc_standby();
      sc_one_shot();
      sc_remote_only();
      sc_fault();
      sc_refused();
      sc_glitch();
      sc_timeout();
      complete_run();
   end
endmodule
